// File: adc_seq_pkg.sv
// shared constants and carrier types for the six-channel conversion sequencer
package adc_seq_pkg;

	// channel organisation
	localparam int NUM_PAIRS = 3;
	localparam int NUM_CH = 6;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;

	// clock rates and the conversion clock divider
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int CONV_CLK_HZ = 5_000_000;
	localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
	localparam int DIV_W = 4;

	// conversion timing in conversion clock periods
	localparam int CYCLE_PERIODS = 20;
	localparam int LATCH_PERIODS = 16;
	localparam int CNT_W = 5;

	// read select codes
	localparam logic [2:0] SEL_CYCLE = 3'h6;
	localparam logic [2:0] SEL_FIFO = 3'h7;

	// tag word layout: valid, first-slot, padding, slot address
	localparam int TAG_VALID_BIT = 15;
	localparam int TAG_FIRST_BIT = 14;
	localparam int TAG_PAD_W = 11;

	// values after reset
	localparam logic [WORD_W-1:0] RESULT_RST = 16'h0000;
	localparam logic [2:0] TRIG_IDLE = 3'h7;
	localparam logic [9:0] PINS_IDLE = 10'h3E0;

	// pins from the host side, all asynchronous to clk
	typedef struct packed {
		logic [NUM_PAIRS-1:0] pair_trigger_n;
		logic rd_n;
		logic cs_n;
		logic [2:0] read_select;
		logic byte_mode;
		logic add_tag;
	} pin_bus_t;

	// per-pair conversion timer state
	typedef struct packed {
		logic armed;
		logic busy;
		logic req;
		logic [CNT_W-1:0] cnt;
	} pair_state_t;

	// whole sequencer state
	typedef struct packed {
		logic [NUM_CH-1:0][WORD_W-1:0] results;
		logic [NUM_CH-1:0] valid;
		logic [DIV_W-1:0] div_cnt;
		logic [DIV_W-1:0] eoc_cnt;
		logic eoc_n;
		logic defer;
		logic active;
		logic [1:0] phase;
		logic [2:0] cyc_ptr;
		logic [2:0] wr_ptr;
		logic [2:0] rd_ptr;
		logic [2:0] count;
		logic [NUM_PAIRS-1:0] trig_prev;
		logic [NUM_PAIRS-1:0] sampling;
		logic [WORD_W-1:0] data_out;
		logic data_oe;
		logic first_flag;
	} seq_state_t;

endpackage

// File: pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 10,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// first stage feeds only the second stage
	always_comb begin
		state_next = state_reg;
		state_next.s1 = d;
		state_next.s2 = state_reg.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.s1 <= RST_VAL;
			state_reg.s2 <= RST_VAL;
		end else begin
			state_reg <= state_next;
		end
	end

	assign q = state_reg.s2;
endmodule

// File: pair_timer.sv
// conversion timer for one channel pair
`timescale 1ns/10ps
module pair_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rise,
	input wire logic trig_fall,
	input wire logic grant,
	output logic req,
	output logic sampling,
	output logic busy
);
	localparam logic [adc_seq_pkg::CNT_W-1:0] CNT_LATCH = adc_seq_pkg::CNT_W'(adc_seq_pkg::LATCH_PERIODS);
	localparam logic [adc_seq_pkg::CNT_W-1:0] CNT_END = adc_seq_pkg::CNT_W'(adc_seq_pkg::CYCLE_PERIODS);

	adc_seq_pkg::pair_state_t state_reg;
	adc_seq_pkg::pair_state_t state_next;

	// arm on a trigger edge, start on the next rise, request latch at 16, end at 20
	always_comb begin
		state_next = state_reg;
		if (trig_fall && !state_reg.busy && !state_reg.armed) begin
			state_next.armed = 1'b1;
		end
		if (state_reg.armed && rise) begin
			state_next.armed = 1'b0;
			state_next.busy = 1'b1;
			state_next.cnt = '0;
		end else if (state_reg.busy && rise && state_reg.cnt != CNT_END) begin
			state_next.cnt = state_reg.cnt + 5'h01;
			if (state_reg.cnt == CNT_LATCH - 5'h01) begin
				state_next.req = 1'b1;
			end
		end
		if (grant) begin
			state_next.req = 1'b0;
		end
		if (state_reg.busy && state_reg.cnt == CNT_END && !state_reg.req) begin
			state_next.busy = 1'b0;
		end
	end

	// reset aborts the conversion and reopens the sampling switches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign req = state_reg.req;
	assign busy = state_reg.busy;
	assign sampling = !(state_reg.busy && state_reg.cnt < CNT_LATCH);

	a_latch_at_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state_reg.req) |-> state_reg.cnt == 5'h10)
		else $error("latch request not at count 16");
	a_start_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state_reg.busy) |-> $past(rise) && $past(state_reg.armed))
		else $error("conversion started off a clock rise");
	a_trig_ignored_busy: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.busy && !(state_reg.cnt == CNT_END && !state_reg.req) |=> !state_reg.armed)
		else $error("trigger accepted during conversion");
	a_cycle_length: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(state_reg.busy) |-> $past(state_reg.cnt) == 5'h14)
		else $error("conversion cycle not 20 periods");
endmodule

// File: adc_seq.sv
// six-channel conversion sequencer: timing, result latching and parallel readout
// Function
// - all timing derives from the conversion clock; one cycle is 20 periods
// - each pair trigger starts only its own pair; all three start all six
// - six separate result registers, one per channel result
// - each read access presents one 16-bit data or tag word, or one data byte in byte mode
// - read select chooses direct channel, cycle, or trigger-ordered FIFO readout
// - in FIFO readout one pair may fill all six registers
// - reset clears results, aborts conversions, reopens sampling switches
// - result latched 16.5 periods after start, end-of-conversion goes low then
// - end-of-conversion stays low half a period per latch
// - simultaneous pairs latch A first, B one period later, C after that
// - a result ready during a read is latched after the read ends
// - first-slot flag high when the pair A first slot is next to read
// - earliest FIFO first-channel result goes into the pair A first slot
// - in FIFO readout flag is 0 while empty, rises on first entry
// - in cycle and FIFO readout flag falls once the flagged channel is completely read
// - codes 0-5 address A0..C1, 6 cycle mode, 7 FIFO mode
// - start on next clock rise after trigger edge; ignore edges until done
// - data outputs driven only while read strobe and chip select both low
`timescale 1ns/10ps
module adc_seq #(
	parameter int CONV_DIV = adc_seq_pkg::CONV_DIV
) (
	input wire logic clk,
	input wire logic rstn,
	input wire adc_seq_pkg::pin_bus_t pins,
	input wire logic [adc_seq_pkg::NUM_CH-1:0][adc_seq_pkg::WORD_W-1:0] conv_result,
	output logic [adc_seq_pkg::WORD_W-1:0] data_out,
	output logic data_oe,
	output logic eoc_n,
	output logic first_slot_flag,
	output logic [adc_seq_pkg::NUM_PAIRS-1:0] sampling
);
	localparam logic [adc_seq_pkg::DIV_W-1:0] DIV_LAST = adc_seq_pkg::DIV_W'(CONV_DIV - 1);
	localparam logic [adc_seq_pkg::DIV_W-1:0] DIV_HALF = adc_seq_pkg::DIV_W'(CONV_DIV / 2);
	localparam logic [adc_seq_pkg::DIV_W-1:0] EOC_LOW_LAST = adc_seq_pkg::DIV_W'(CONV_DIV / 2 - 1);
	localparam logic [2:0] FIFO_ROOM = 3'(adc_seq_pkg::NUM_CH - 2);
	localparam logic [2:0] SLOT_LAST = 3'(adc_seq_pkg::NUM_CH - 1);

	logic [1:0] rst_sync_reg;
	logic rst_n;
	adc_seq_pkg::pin_bus_t pins_s;
	adc_seq_pkg::seq_state_t state_reg;
	adc_seq_pkg::seq_state_t state_next;
	logic rise;
	logic fall;
	logic active_now;
	logic read_end;
	logic complete;
	logic mode_fifo;
	logic mode_cycle;
	logic tag_on;
	logic [1:0] last_phase;
	logic [1:0] word_idx;
	logic [2:0] sel_slot;
	logic [adc_seq_pkg::WORD_W-1:0] sel_data;
	logic [adc_seq_pkg::WORD_W-1:0] word;
	logic [adc_seq_pkg::NUM_PAIRS-1:0] trig_fall;
	logic [adc_seq_pkg::NUM_PAIRS-1:0] req;
	logic [adc_seq_pkg::NUM_PAIRS-1:0] grant;
	logic [adc_seq_pkg::NUM_PAIRS-1:0] pair_sampling;
	logic [adc_seq_pkg::NUM_PAIRS-1:0] pair_busy;
	logic do_latch;
	logic push;
	logic pop;

	function automatic logic [2:0] slot_inc(input logic [2:0] x);
		slot_inc = (x == SLOT_LAST) ? 3'h0 : 3'(x + 3'h1);
	endfunction

	// reset release through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	pin_sync #(
		.W($bits(adc_seq_pkg::pin_bus_t)),
		.RST_VAL(adc_seq_pkg::PINS_IDLE)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(pins),
		.q(pins_s)
	);

	// conversion clock rise and mid-period pulses from the divider
	assign rise = (state_reg.div_cnt == '0);
	assign fall = (state_reg.div_cnt == DIV_HALF);
	assign trig_fall = state_reg.trig_prev & ~pins_s.pair_trigger_n;

	// one timer per pair, each started only by its own trigger
	for (genvar p = 0; p < adc_seq_pkg::NUM_PAIRS; p++) begin : g_pair
		pair_timer u_timer (
			.clk(clk),
			.rst_n(rst_n),
			.rise(rise),
			.trig_fall(trig_fall[p]),
			.grant(grant[p]),
			.req(req[p]),
			.sampling(pair_sampling[p]),
			.busy(pair_busy[p])
		);
	end

	// read access tracking
	assign active_now = !pins_s.rd_n && !pins_s.cs_n;
	assign read_end = state_reg.active && !active_now;

	// latch one pair per half-period point, A before B before C, never during a read
	assign do_latch = !active_now && (fall || state_reg.defer) && (|req);
	assign grant[0] = do_latch && req[0];
	assign grant[1] = do_latch && req[1] && !req[0];
	assign grant[2] = do_latch && req[2] && !req[1] && !req[0];

	// readout mode and slot selection
	assign mode_fifo = (pins_s.read_select == adc_seq_pkg::SEL_FIFO);
	assign mode_cycle = (pins_s.read_select == adc_seq_pkg::SEL_CYCLE);
	assign sel_slot = mode_fifo ? state_reg.rd_ptr : (mode_cycle ? state_reg.cyc_ptr : pins_s.read_select);
	assign sel_data = state_reg.results[sel_slot];
	assign tag_on = pins_s.add_tag && (mode_fifo || mode_cycle);
	assign last_phase = {1'b0, tag_on} + {1'b0, pins_s.byte_mode};
	assign word_idx = tag_on ? state_reg.phase : 2'(state_reg.phase + 2'h1);
	assign complete = read_end && (state_reg.phase >= last_phase);
	assign pop = complete && mode_fifo && (state_reg.count != 3'h0);
	assign push = mode_fifo && (|grant) && (state_reg.count <= FIFO_ROOM);

	// word for this access: tag, whole word, or byte halves
	always_comb begin
		word = sel_data;
		if (word_idx == 2'h0) begin
			word = '0;
			word[adc_seq_pkg::TAG_VALID_BIT] = state_reg.valid[sel_slot];
			word[adc_seq_pkg::TAG_FIRST_BIT] = state_reg.first_flag;
			word[2:0] = sel_slot;
		end else if (pins_s.byte_mode && word_idx == 2'h1) begin
			word = {8'h00, sel_data[adc_seq_pkg::BYTE_W-1:0]};
		end else if (pins_s.byte_mode) begin
			word = {8'h00, sel_data[adc_seq_pkg::WORD_W-1:adc_seq_pkg::BYTE_W]};
		end
	end

	// next state of the whole sequencer
	always_comb begin
		state_next = state_reg;
		state_next.div_cnt = (state_reg.div_cnt == DIV_LAST) ? '0 : 4'(state_reg.div_cnt + 4'h1);
		state_next.trig_prev = pins_s.pair_trigger_n;
		state_next.active = active_now;
		state_next.sampling = pair_sampling;
		// access phase advances at the end of each access, pointers once the slot is completely read
		if (read_end) begin
			state_next.phase = complete ? 2'h0 : 2'(state_reg.phase + 2'h1);
		end
		if (complete && mode_cycle) begin
			state_next.cyc_ptr = slot_inc(state_reg.cyc_ptr);
		end
		if (complete) begin
			state_next.valid[sel_slot] = 1'b0;
		end
		if (pop) begin
			state_next.rd_ptr = slot_inc(state_reg.rd_ptr);
			state_next.count = 3'(state_next.count - 3'h1);
		end
		// result latching; a set wins over the clear above
		for (int p = 0; p < adc_seq_pkg::NUM_PAIRS; p++) begin
			if (grant[p] && !mode_fifo) begin
				state_next.results[2*p] = conv_result[2*p];
				state_next.results[2*p+1] = conv_result[2*p+1];
				state_next.valid[2*p] = 1'b1;
				state_next.valid[2*p+1] = 1'b1;
			end else if (grant[p] && push) begin
				state_next.results[state_reg.wr_ptr] = conv_result[2*p];
				state_next.results[slot_inc(state_reg.wr_ptr)] = conv_result[2*p+1];
				state_next.valid[state_reg.wr_ptr] = 1'b1;
				state_next.valid[slot_inc(state_reg.wr_ptr)] = 1'b1;
				state_next.wr_ptr = slot_inc(slot_inc(state_reg.wr_ptr));
			end
		end
		if (push) begin
			state_next.count = 3'(state_next.count + 3'h2);
		end
		// defer a latch that fell due during a read
		if (do_latch) begin
			state_next.defer = 1'b0;
		end else if (fall && (|req) && active_now) begin
			state_next.defer = 1'b1;
		end
		// end-of-conversion low for half a conversion period
		if (do_latch) begin
			state_next.eoc_n = 1'b0;
			state_next.eoc_cnt = EOC_LOW_LAST;
		end else if (!state_reg.eoc_n) begin
			if (state_reg.eoc_cnt == '0) begin
				state_next.eoc_n = 1'b1;
			end else begin
				state_next.eoc_cnt = 4'(state_reg.eoc_cnt - 4'h1);
			end
		end
		// bus drive only inside an access
		state_next.data_oe = active_now;
		state_next.data_out = active_now ? word : '0;
		// first-slot flag follows the slot that is read next
		if (mode_fifo) begin
			state_next.first_flag = (state_next.count != 3'h0) && (state_next.rd_ptr == 3'h0);
		end else if (mode_cycle) begin
			state_next.first_flag = (state_next.cyc_ptr == 3'h0);
		end else begin
			state_next.first_flag = (pins_s.read_select == 3'h0);
		end
	end

	// state register; reset clears results, queue and pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.eoc_n <= 1'b1;
			state_reg.trig_prev <= adc_seq_pkg::TRIG_IDLE;
			state_reg.sampling <= adc_seq_pkg::TRIG_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign data_out = state_reg.data_out;
	assign data_oe = state_reg.data_oe;
	assign eoc_n = state_reg.eoc_n;
	assign first_slot_flag = state_reg.first_flag;
	assign sampling = state_reg.sampling;

	// low-time counter for the end-of-conversion width check; a new latch restarts it
	logic [adc_seq_pkg::DIV_W-1:0] eoc_low_run;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eoc_low_run <= '0;
		end else if (do_latch) begin
			eoc_low_run <= adc_seq_pkg::DIV_W'(1);
		end else begin
			eoc_low_run <= state_next.eoc_n ? '0 : adc_seq_pkg::DIV_W'(eoc_low_run + 4'h1);
		end
	end

	// checks next to the logic they guard
	a_latch_not_in_read: assert property (@(posedge clk) disable iff (!rst_n)
		(|grant) |-> !active_now)
		else $error("result latched during a read access");
	a_eoc_half_period: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state_reg.eoc_n) |-> $past(eoc_low_run) == DIV_HALF)
		else $error("end-of-conversion low width wrong");
	a_eoc_at_latch: assert property (@(posedge clk) disable iff (!rst_n)
		(|grant) |=> !state_reg.eoc_n && (state_reg.valid != 6'h00 || $past(mode_fifo)))
		else $error("latch without end-of-conversion");
	a_stagger_order: assert property (@(posedge clk) disable iff (!rst_n)
		req[0] && (|grant) |-> grant == 3'h1)
		else $error("pair A not latched first");
	a_oe_only_read: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.data_oe |-> $past(active_now))
		else $error("bus driven outside a read");
	a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.count <= 3'h6)
		else $error("fifo count above six");
	a_fifo_empty_flag: assert property (@(posedge clk) disable iff (!rst_n)
		mode_fifo && state_reg.count == 3'h0 ##1 mode_fifo && $stable(state_reg.count) |-> !state_reg.first_flag)
		else $error("first-slot flag high on empty fifo");
	a_cycle_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		complete && mode_cycle && state_reg.cyc_ptr == 3'h5 |=> state_reg.cyc_ptr == 3'h0)
		else $error("cycle pointer did not wrap");
	a_direct_latch: assert property (@(posedge clk) disable iff (!rst_n)
		grant[1] && !mode_fifo |=> state_reg.valid[2] && state_reg.valid[3])
		else $error("pair B result not stored");
	a_first_flag_direct: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_fifo && !mode_cycle |=> state_reg.first_flag == ($past(pins_s.read_select) == 3'h0))
		else $error("first-slot flag wrong in direct readout");
	a_flag_falls_read: assert property (@(posedge clk) disable iff (!rst_n)
		pop && state_reg.rd_ptr == 3'h0 |=> !state_reg.first_flag)
		else $error("first-slot flag stayed high after its channel was read");
	a_fifo_first_slot: assert property (@(posedge clk) disable iff (!rst_n)
		grant[1] && push && state_reg.wr_ptr == 3'h0 |=> state_reg.results[0] == $past(conv_result[2]))
		else $error("first queued result not in slot zero");
	a_pop_count: assert property (@(posedge clk) disable iff (!rst_n)
		pop && !push |=> state_reg.count == 3'($past(state_reg.count) - 3'h1))
		else $error("queue count not lowered by a completed read");
	a_cycle_advance: assert property (@(posedge clk) disable iff (!rst_n)
		complete && mode_cycle |=> state_reg.cyc_ptr != $past(state_reg.cyc_ptr))
		else $error("cycle pointer did not advance");
	a_single_grant: assert property (@(posedge clk) disable iff (!rst_n)
		$onehot0(grant))
		else $error("two pairs latched in one cycle");
	a_defer_release: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.defer && !active_now |-> (|grant))
		else $error("deferred latch not taken after the read");
	a_tag_padding: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.data_oe && $past(word_idx) == 2'h0 |-> state_reg.data_out[13:3] == 11'h000)
		else $error("tag word padding not zero");
	a_idle_bus_zero: assert property (@(posedge clk) disable iff (!rst_n)
		!state_reg.data_oe |-> state_reg.data_out == 16'h0000)
		else $error("data bus not zero outside a read");

	c_fifo_full: cover property (@(posedge clk) disable iff (!rst_n) state_reg.count == 3'h6);
	c_deferred_latch: cover property (@(posedge clk) disable iff (!rst_n) state_reg.defer ##[1:40] (|grant));
	c_cycle_wrap: cover property (@(posedge clk) disable iff (!rst_n) complete && mode_cycle && state_reg.cyc_ptr == 3'h5);
	c_all_pairs: cover property (@(posedge clk) disable iff (!rst_n) pair_busy == 3'h7);
	c_tagged_bytes: cover property (@(posedge clk) disable iff (!rst_n) complete && tag_on && pins_s.byte_mode);
endmodule

// File: host_model.sv
// host controller model driving the parallel read strobes
`timescale 1ns/10ps
module host_model (
	input wire logic clk,
	input wire logic [15:0] data_out,
	input wire logic data_oe,
	output logic rd_n,
	output logic cs_n,
	output logic [2:0] read_select,
	output logic byte_mode,
	output logic add_tag
);
	// bus idle with both strobes high
	initial begin
		rd_n = 1'b1;
		cs_n = 1'b1;
		read_select = 3'h0;
		byte_mode = 1'b0;
		add_tag = 1'b0;
	end

	// mode pins change only while idle, then settle through the synchroniser
	task automatic set_mode(input logic [2:0] sel, input logic bm, input logic tg);
		@(posedge clk);
		read_select <= sel;
		byte_mode <= bm;
		add_tag <= tg;
		repeat (4) @(posedge clk);
	endtask

	// one access; strobes held until the answer, plus hold cycles
	task automatic read_word(input logic [2:0] sel, input logic bm, input logic tg, input int hold,
		output logic [15:0] word);
		int n;
		set_mode(sel, bm, tg);
		rd_n <= 1'b0;
		cs_n <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (data_oe !== 1'b1 && n < 12);
		repeat (hold) @(negedge clk);
		word = (data_oe === 1'b1) ? data_out : 16'hxxxx;
		@(posedge clk);
		rd_n <= 1'b1;
		cs_n <= 1'b1;
		// strobe high long enough to be seen before the next access
		repeat (5) @(posedge clk);
	endtask
endmodule

// File: six_channel_adc_conversion_sequencer_tb_top.sv
// self-checking bench for the six-channel conversion sequencer
`timescale 1ns/10ps
module six_channel_adc_conversion_sequencer_tb_top;
	localparam int DIV = 4;
	typedef struct packed {
		logic [2:0] sel;
		logic bm;
		logic tg;
		logic [15:0] exp;
		logic [15:0] mask;
	} row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] trig_n = 3'h7;
	logic [5:0][15:0] conv = {16'hBC05, 16'h9A04, 16'h7803, 16'h5602, 16'h3401, 16'h1200};
	adc_seq_pkg::pin_bus_t pins;
	logic rd_n;
	logic cs_n;
	logic byte_mode;
	logic add_tag;
	logic [2:0] read_select;
	logic [15:0] data_out;
	logic data_oe;
	logic eoc_n;
	logic first_slot_flag;
	logic [2:0] sampling;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int falls[$];
	int low_run = 0;
	int last_w = 0;
	int t0 = 0;
	logic eoc_prev = 1'b1;
	logic [15:0] word;
	// tagged and plain cycle reads with wrap, each clearing its slot's valid bit, then direct, byte split, tag plus bytes
	row_t rows [20] = '{
		'{3'h6, 1'b0, 1'b1, 16'hC000, 16'hFFFF}, '{3'h6, 1'b0, 1'b1, 16'h1200, 16'hFFFF},
		'{3'h6, 1'b0, 1'b1, 16'h8001, 16'hFFFF}, '{3'h6, 1'b0, 1'b1, 16'h3401, 16'hFFFF},
		'{3'h6, 1'b0, 1'b0, 16'h5602, 16'hFFFF}, '{3'h6, 1'b0, 1'b0, 16'h7803, 16'hFFFF},
		'{3'h6, 1'b0, 1'b0, 16'h9A04, 16'hFFFF}, '{3'h6, 1'b0, 1'b0, 16'hBC05, 16'hFFFF},
		'{3'h0, 1'b0, 1'b0, 16'h1200, 16'hFFFF}, '{3'h1, 1'b0, 1'b0, 16'h3401, 16'hFFFF},
		'{3'h2, 1'b0, 1'b0, 16'h5602, 16'hFFFF}, '{3'h3, 1'b0, 1'b0, 16'h7803, 16'hFFFF},
		'{3'h4, 1'b0, 1'b0, 16'h9A04, 16'hFFFF}, '{3'h5, 1'b0, 1'b0, 16'hBC05, 16'hFFFF},
		'{3'h2, 1'b1, 1'b0, 16'h0002, 16'h00FF}, '{3'h2, 1'b1, 1'b0, 16'h0056, 16'h00FF},
		'{3'h6, 1'b0, 1'b0, 16'h1200, 16'hFFFF}, '{3'h6, 1'b1, 1'b1, 16'h0001, 16'hFFFF},
		'{3'h6, 1'b1, 1'b1, 16'h0001, 16'h00FF}, '{3'h6, 1'b1, 1'b1, 16'h0034, 16'h00FF}};

	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	assign pins = '{trig_n, rd_n, cs_n, read_select, byte_mode, add_tag};

	// record end-of-conversion falls and low widths
	always @(negedge clk) begin
		if (eoc_prev === 1'b1 && eoc_n === 1'b0) falls.push_back(cyc);
		if (eoc_n === 1'b0) low_run = low_run + 1;
		else begin
			if (low_run != 0) last_w = low_run;
			low_run = 0;
		end
		eoc_prev = eoc_n;
	end

	adc_seq #(.CONV_DIV(DIV)) u_adc_seq (.clk(clk), .rstn(rstn), .pins(pins), .conv_result(conv),
		.data_out(data_out), .data_oe(data_oe), .eoc_n(eoc_n), .first_slot_flag(first_slot_flag),
		.sampling(sampling));
	host_model u_host_model (.clk(clk), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .cs_n(cs_n),
		.read_select(read_select), .byte_mode(byte_mode), .add_tag(add_tag));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_idle;
		chk("idle outputs", 16'h001F, {10'h0, data_oe, eoc_n, first_slot_flag, sampling});
		chk("idle data", 16'h0000, data_out);
	endtask

	// trigger the given pairs, low for six cycles
	task automatic pulse(input logic [2:0] m);
		@(posedge clk);
		trig_n <= ~m;
		repeat (6) @(posedge clk);
		trig_n <= 3'h7;
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk_idle();
		// one pair alone, second edge while busy is ignored
		t0 = cyc;
		pulse(3'h2);
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("pair b sampling", 16'h0005, {13'h0, sampling});
		repeat (4) @(posedge clk);
		pulse(3'h2);
		repeat (150) @(posedge clk);
		chk("one latch", 16'h1, 16'(falls.size()));
		chk("latch delay", 16'h1, {15'h0, falls.size() > 0 && falls[0] - t0 >= 16 * DIV + DIV / 2
			&& falls[0] - t0 <= 17 * DIV + 8});
		chk("eoc width", 16'(DIV / 2), 16'(last_w));
		// all three pairs together, staggered latches
		falls.delete();
		pulse(3'h7);
		repeat (150) @(posedge clk);
		chk("three latches", 16'h3, 16'(falls.size()));
		chk("stagger", 16'h1, {15'h0, falls.size() == 3 && falls[1] - falls[0] == DIV
			&& falls[2] - falls[1] == DIV});
		foreach (rows[i]) begin
			u_host_model.read_word(rows[i].sel, rows[i].bm, rows[i].tg, 1, word);
			chk("row word", rows[i].exp, word & rows[i].mask);
		end
		u_host_model.set_mode(3'h1, 1'b0, 1'b0);
		chk("flag other slot", 16'h0, {15'h0, first_slot_flag});
		u_host_model.set_mode(3'h0, 1'b0, 1'b0);
		chk("flag slot zero", 16'h1, {15'h0, first_slot_flag});
		// latch due during a long read waits for its end
		@(posedge clk);
		conv[0] <= 16'h4E4E;
		falls.delete();
		t0 = cyc;
		pulse(3'h1);
		repeat (48) @(posedge clk);
		u_host_model.read_word(3'h0, 1'b0, 1'b0, 40, word);
		repeat (20) @(posedge clk);
		chk("deferred latch", 16'h1, {15'h0, falls.size() == 1 && falls[0] - t0 > 17 * DIV + 10
			&& falls[0] - t0 < 130});
		u_host_model.read_word(3'h0, 1'b0, 1'b0, 1, word);
		chk("new slot zero", 16'h4E4E, word);
		// reset in mid conversion aborts it and clears results
		pulse(3'h4);
		repeat (20) @(posedge clk);
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		falls.delete();
		repeat (120) @(posedge clk);
		chk("aborted", 16'h0, 16'(falls.size()));
		@(negedge clk);
		chk_idle();
		u_host_model.read_word(3'h4, 1'b0, 1'b0, 1, word);
		chk("cleared result", 16'h0, word);
		// one pair fills the whole queue
		u_host_model.set_mode(3'h7, 1'b0, 1'b0);
		chk("flag empty queue", 16'h0, {15'h0, first_slot_flag});
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			conv[2] <= 16'h1B00 + 16'(k);
			conv[3] <= 16'h2B00 + 16'(k);
			pulse(3'h2);
			repeat (100) @(posedge clk);
			if (k == 0) chk("flag first entry", 16'h1, {15'h0, first_slot_flag});
		end
		for (int k = 0; k < 6; k++) begin
			u_host_model.read_word(3'h7, 1'b0, 1'b0, 1, word);
			chk("queue word", (k % 2 == 1 ? 16'h2B00 : 16'h1B00) + 16'(k / 2), word);
			if (k == 0) chk("flag after read", 16'h0, {15'h0, first_slot_flag});
		end
		u_host_model.read_word(3'h7, 1'b0, 1'b1, 1, word);
		chk("empty tag valid", 16'h0, {15'h0, word[15]});
		tally_and_finish();
	end

	// watchdog well beyond the expected run of about 1430 cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
